/* calc_unit.v */
`include "power_monitor_map.vh"

// per-sample current and power, one cycle behind each result
module calc_unit (
	// clock and reset
	input  wire               clk,
	input  wire               rst,
	// raw results
	input  wire               shunt_valid,
	input  wire        [15:0] shunt_data,
	input  wire               bus_valid,
	input  wire        [15:0] bus_data,
	input  wire        [15:0] calibration,
	// per-sample results
	output reg  signed [15:0] current_sample,
	output reg         [15:0] power_sample,
	output reg                power_valid
);

	wire signed [31:0] cur_product;
	wire        [15:0] cur_mag;
	wire        [31:0] pow_product;

	assign cur_product = $signed(shunt_data) * $signed({1'b0, calibration[14:0]});
	assign cur_mag     = current_sample[15] ? (~current_sample + 16'h0001) : current_sample;
	assign pow_product = cur_mag * bus_data;

	always @(posedge clk) begin
		if (rst) begin
			current_sample <= 16'h0000;
			power_sample   <= 16'h0000;
			power_valid    <= 1'b0;
		end else begin
			power_valid <= bus_valid;
			if (shunt_valid)
				current_sample <= cur_product[`CURRENT_SHIFT+15:`CURRENT_SHIFT];
			if (bus_valid) begin
				if (calibration == 16'h0000)
					power_sample <= 16'h0000;
				else
					power_sample <= pow_product[`POWER_SHIFT+15:`POWER_SHIFT];
			end
		end
	end

endmodule // calc_unit

/* conv_model.sv */
// shared converter: one conversion at a time, result after a fixed delay
module conv_model (
	// clock and reset
	input  wire logic        clk,
	input  wire logic        rst,
	// converter handshake
	input  wire logic        start,
	input  wire logic        is_bus,
	output logic             done,
	output logic      [15:0] data,
	// results handed back
	input  wire logic [15:0] shunt_val,
	input  wire logic [15:0] bus_val
);
	timeunit 1ns;
	timeprecision 1ns;
	parameter int DLY = 8;
	int   cnt;
	logic bus_q;
	initial begin
		done = 1'b0;
		data = 16'h0000;
	end
	// data line is not held outside the done pulse
	always @(posedge clk) begin
		done <= 1'b0;
		data <= ~data;
		if (rst) begin
			cnt <= 0;
		end else if (start) begin
			cnt   <= DLY;
			bus_q <= is_bus;
		end else if (cnt == 1) begin
			done <= 1'b1;
			data <= bus_q ? bus_val : shunt_val;
			cnt  <= 0;
		end else if (cnt > 1) begin
			cnt <= cnt - 1;
		end
	end
endmodule // conv_model

/* power_monitor_alert_logic.v */
// Behaviour
// - one shared 16-bit converter, shunt then bus, never both at once
// - power uses latest current and newest bus result after both conversions
// - zero calibration gives zero power
// - averaging above one accumulates current and power samples; those outputs load after the last sample, shunt and bus load every conversion
// - arithmetic overlaps the next conversion, adding no cycle time
// - event select register picks limit function and ready enable; threshold register
// - functions: shunt over, shunt under, bus over, bus under, power over
// - open-drain event output asserts when selected function sees a violation
// - several enabled functions: highest bit wins, others ignored
// - ready enable clear: output follows limit violations only
// - shunt functions compare after every shunt conversion
// - limit flag set on violation; output level chosen by polarity bit D1
// - latched: flag and output hold until config write, event register read, or an event select write leaving no function enabled
// - bus functions compare after every bus conversion
// - power over-limit compares calculated power after every bus conversion
// - compare individual results, never averaged outputs
// - ready enable set: output signals completed conversion cycle
// - done flag set at cycle end; cleared by non-off config write or event read
// - mode 111 converts continuously, shunt then bus
`include "power_monitor_map.vh"

module power_monitor_alert_logic (
	// clock and reset
	input  wire        CLOCK,
	input  wire        RST,
	// register port from the serial engine
	input  wire        REG_WR,
	input  wire        REG_RD,
	input  wire [7:0]  REG_ADDR,
	input  wire [15:0] REG_WDATA,
	output reg  [15:0] REG_RDATA,
	// shared converter
	output reg         CONV_START,
	output reg         CONV_IS_BUS,
	input  wire        CONV_DONE,
	input  wire [15:0] CONV_DATA,
	// open-drain event pin
	output reg         ALERT_OUT,
	output reg         ALERT_OE
);

	localparam [2:0] S_IDLE  = 3'b001;
	localparam [2:0] S_SHUNT = 3'b010;
	localparam [2:0] S_BUS   = 3'b100;

	reg         [2:0]  state;
	reg         [15:0] config_reg;
	reg         [15:0] event_select;
	reg         [15:0] event_threshold;
	reg         [15:0] calibration;
	reg         [15:0] shunt_reg;
	reg         [15:0] bus_reg;
	reg         [15:0] current_reg;
	reg         [15:0] power_reg;
	reg                trigger_pending;
	reg                limit_hit_flag;
	reg                conversion_done_flag;
	reg         [9:0]  sample_idx;
	reg  signed [25:0] current_acc;
	reg         [25:0] power_acc;
	reg                shunt_valid;
	reg                bus_valid;
	reg         [2:0]  active_fn;
	reg                compare_now;
	reg                violation;
	reg         [3:0]  avg_shift;

	wire signed [15:0] current_sample;
	wire        [15:0] power_sample;
	wire               power_valid;
	wire        [2:0]  mode;
	wire               mode_off;
	wire               cfg_write;
	wire               event_read;
	wire        [9:0]  last_idx;
	wire signed [25:0] current_total;
	wire        [25:0] power_total;
	wire signed [25:0] current_avg;
	wire        [25:0] power_avg;
	wire               cycle_end;
	wire               ready_drive;
	wire               pin_active;
	wire        [15:0] next_wdata_cfg;

	assign mode           = config_reg[`CFG_MODE_MSB:`CFG_MODE_LSB];
	assign next_wdata_cfg = REG_WDATA;
	assign mode_off       = (next_wdata_cfg[`CFG_MODE_MSB:`CFG_MODE_LSB] == `MODE_OFF_A) ||
	                        (next_wdata_cfg[`CFG_MODE_MSB:`CFG_MODE_LSB] == `MODE_OFF_B);
	assign cfg_write      = REG_WR && (REG_ADDR == `OFS_CONFIG);
	assign event_read     = REG_RD && (REG_ADDR == `OFS_EVENT_SELECT);

	// averaging count as a power of two
	always @* begin
		case (config_reg[`CFG_AVG_MSB:`CFG_AVG_LSB])
			3'h0:    avg_shift = 4'h0;
			3'h1:    avg_shift = 4'h2;
			3'h2:    avg_shift = 4'h4;
			3'h3:    avg_shift = 4'h6;
			3'h4:    avg_shift = 4'h7;
			3'h5:    avg_shift = 4'h8;
			3'h6:    avg_shift = 4'h9;
			default: avg_shift = 4'hA;
		endcase
	end

	assign last_idx      = (10'h001 << avg_shift) - 10'h001;
	assign current_total = (sample_idx == 10'h000) ? {{10{current_sample[15]}}, current_sample}
	                                               : current_acc + {{10{current_sample[15]}}, current_sample};
	assign power_total   = (sample_idx == 10'h000) ? {10'h000, power_sample}
	                                               : power_acc + {10'h000, power_sample};
	assign current_avg   = current_total >>> avg_shift;
	assign power_avg     = power_total >> avg_shift;
	assign cycle_end     = power_valid && (sample_idx == last_idx);

	calc_unit u_calc (
		.clk            (CLOCK),
		.rst            (RST),
		.shunt_valid    (shunt_valid),
		.shunt_data     (shunt_reg),
		.bus_valid      (bus_valid),
		.bus_data       (bus_reg),
		.calibration    (calibration),
		.current_sample (current_sample),
		.power_sample   (power_sample),
		.power_valid    (power_valid)
	);

	// conversion sequencer: one converter, shunt then bus
	always @(posedge CLOCK) begin
		if (RST) begin
			state           <= S_IDLE;
			CONV_START      <= 1'b0;
			CONV_IS_BUS     <= 1'b0;
			trigger_pending <= 1'b0;
			shunt_valid     <= 1'b0;
			bus_valid       <= 1'b0;
			shunt_reg       <= 16'h0000;
			bus_reg         <= 16'h0000;
		end else begin
			CONV_START  <= 1'b0;
			shunt_valid <= 1'b0;
			bus_valid   <= 1'b0;
			if (cfg_write) begin
				state           <= S_IDLE;
				trigger_pending <= !mode_off;
			end else begin
				case (state)
					S_IDLE: begin
						if (mode == `MODE_CONTINUOUS || trigger_pending) begin
							CONV_START  <= 1'b1;
							CONV_IS_BUS <= 1'b0;
							state       <= S_SHUNT;
						end
					end
					S_SHUNT: begin
						if (CONV_DONE) begin
							shunt_reg   <= CONV_DATA;
							shunt_valid <= 1'b1;
							CONV_START  <= 1'b1;
							CONV_IS_BUS <= 1'b1;
							state       <= S_BUS;
						end
					end
					S_BUS: begin
						if (CONV_DONE) begin
							bus_reg   <= CONV_DATA;
							bus_valid <= 1'b1;
							if (mode == `MODE_CONTINUOUS || sample_idx != last_idx) begin
								CONV_START  <= 1'b1;
								CONV_IS_BUS <= 1'b0;
								state       <= S_SHUNT;
							end else begin
								trigger_pending <= 1'b0;
								state           <= S_IDLE;
							end
						end
					end
					default: state <= S_IDLE;
				endcase
			end
		end
	end

	// accumulation and output loading
	always @(posedge CLOCK) begin
		if (RST) begin
			sample_idx  <= 10'h000;
			current_acc <= 26'h0000000;
			power_acc   <= 26'h0000000;
			current_reg <= 16'h0000;
			power_reg   <= 16'h0000;
		end else if (cfg_write) begin
			sample_idx <= 10'h000;
		end else if (power_valid) begin
			current_acc <= current_total;
			power_acc   <= power_total;
			if (cycle_end) begin
				sample_idx  <= 10'h000;
				current_reg <= current_avg[15:0];
				power_reg   <= power_avg[15:0];
			end else begin
				sample_idx <= sample_idx + 10'h001;
			end
		end
	end

	// highest enabled function wins
	always @* begin
		casez (event_select[`EV_SHUNT_OVER:`EV_POWER_OVER])
			5'b1????: active_fn = 3'h1;
			5'b01???: active_fn = 3'h2;
			5'b001??: active_fn = 3'h3;
			5'b0001?: active_fn = 3'h4;
			5'b00001: active_fn = 3'h5;
			default:  active_fn = 3'h0;
		endcase
	end

	// compare each per-sample result (raw shunt or bus, or calculated power) at its own moment
	always @* begin
		compare_now = 1'b0;
		violation   = 1'b0;
		case (active_fn)
			3'h1: begin
				compare_now = shunt_valid;
				violation   = $signed(shunt_reg) > $signed(event_threshold);
			end
			3'h2: begin
				compare_now = shunt_valid;
				violation   = $signed(shunt_reg) < $signed(event_threshold);
			end
			3'h3: begin
				compare_now = bus_valid;
				violation   = bus_reg > event_threshold;
			end
			3'h4: begin
				compare_now = bus_valid;
				violation   = bus_reg < event_threshold;
			end
			3'h5: begin
				compare_now = power_valid;
				violation   = power_sample > event_threshold;
			end
			default: begin
				compare_now = 1'b0;
				violation   = 1'b0;
			end
		endcase
	end

	// flags; a setting event wins over a clear in the same cycle
	always @(posedge CLOCK) begin
		if (RST) begin
			limit_hit_flag       <= 1'b0;
			conversion_done_flag <= 1'b0;
		end else begin
			if (compare_now && violation)
				limit_hit_flag <= 1'b1;
			else if (compare_now && !event_select[`EV_LATCH])
				limit_hit_flag <= 1'b0;
			else if (active_fn == 3'h0)
				limit_hit_flag <= 1'b0;
			else if (event_select[`EV_LATCH] && (event_read || cfg_write))
				limit_hit_flag <= 1'b0;
			if (cycle_end)
				conversion_done_flag <= 1'b1;
			else if (event_read || (cfg_write && !mode_off))
				conversion_done_flag <= 1'b0;
		end
	end

	assign ready_drive = event_select[`EV_READY_ENABLE] && conversion_done_flag;
	assign pin_active  = limit_hit_flag || ready_drive;

	// open-drain pin: pulls low when active level is low
	always @(posedge CLOCK) begin
		if (RST) begin
			ALERT_OUT <= 1'b0;
			ALERT_OE  <= 1'b0;
		end else begin
			ALERT_OUT <= 1'b0;
			ALERT_OE  <= event_select[`EV_POLARITY] ? !pin_active : pin_active;
		end
	end

	// register writes
	always @(posedge CLOCK) begin
		if (RST) begin
			config_reg      <= `RST_CONFIG;
			event_select    <= `RST_EVENT_SELECT;
			event_threshold <= `RST_THRESHOLD;
			calibration     <= `RST_CALIBRATION;
		end else if (REG_WR) begin
			case (REG_ADDR)
				`OFS_CONFIG:       config_reg      <= REG_WDATA;
				`OFS_CALIBRATION:  calibration     <= {1'b0, REG_WDATA[14:0]};
				`OFS_EVENT_SELECT: event_select    <= {REG_WDATA[15:10], 8'h00, REG_WDATA[1:0]};
				`OFS_THRESHOLD:    event_threshold <= REG_WDATA;
				default:           config_reg      <= config_reg;
			endcase
		end
	end

	// registered read data
	always @(posedge CLOCK) begin
		if (RST) begin
			REG_RDATA <= 16'h0000;
		end else if (REG_RD) begin
			case (REG_ADDR)
				`OFS_CONFIG:       REG_RDATA <= config_reg;
				`OFS_SHUNT:        REG_RDATA <= shunt_reg;
				`OFS_BUS:          REG_RDATA <= bus_reg;
				`OFS_POWER:        REG_RDATA <= power_reg;
				`OFS_CURRENT:      REG_RDATA <= current_reg;
				`OFS_CALIBRATION:  REG_RDATA <= calibration;
				`OFS_EVENT_SELECT: REG_RDATA <= {event_select[15:10], 5'h00, limit_hit_flag,
				                                 conversion_done_flag, 1'b0, event_select[1:0]};
				`OFS_THRESHOLD:    REG_RDATA <= event_threshold;
				default:           REG_RDATA <= 16'h0000;
			endcase
		end
	end

endmodule // power_monitor_alert_logic

/* power_monitor_alert_logic_bench.sv */
module power_monitor_alert_logic_bench;
	timeunit 1ns;
	timeprecision 1ns;
	logic        CLOCK = 1'b0;
	logic        RST = 1'b1;
	logic        REG_WR = 1'b0;
	logic        REG_RD = 1'b0;
	logic [7:0]  REG_ADDR = 8'h00;
	logic [15:0] REG_WDATA = 16'h0000;
	logic [15:0] shunt_val = 16'h0200;
	logic [15:0] bus_val = 16'h8000;
	wire  [15:0] REG_RDATA;
	wire  [15:0] CONV_DATA;
	wire         CONV_START, CONV_IS_BUS, CONV_DONE, ALERT_OUT, ALERT_OE;
	logic [15:0] r;
	int          bad_count = 0;
	int          tests_run = 0;
	power_monitor_alert_logic dut (.CLOCK(CLOCK), .RST(RST), .REG_WR(REG_WR), .REG_RD(REG_RD),
		.REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA), .CONV_START(CONV_START),
		.CONV_IS_BUS(CONV_IS_BUS), .CONV_DONE(CONV_DONE), .CONV_DATA(CONV_DATA), .ALERT_OUT(ALERT_OUT),
		.ALERT_OE(ALERT_OE));
	conv_model adc (.clk(CLOCK), .rst(RST), .start(CONV_START), .is_bus(CONV_IS_BUS), .done(CONV_DONE),
		.data(CONV_DATA), .shunt_val(shunt_val), .bus_val(bus_val));
	initial forever #50 CLOCK = ~CLOCK;
	task wrap_up;
		if (bad_count == 0 && tests_run > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task chk(input logic [15:0] got, input logic [15:0] exp);
		tests_run++;
		if (got !== exp) begin
			bad_count++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task wr(input logic [7:0] a, input logic [15:0] d);
		@(negedge CLOCK);
		REG_WR = 1'b1;
		REG_ADDR = a;
		REG_WDATA = d;
		@(negedge CLOCK);
		REG_WR = 1'b0;
	endtask
	task rd(input logic [7:0] a);
		@(negedge CLOCK);
		REG_RD = 1'b1;
		REG_ADDR = a;
		@(negedge CLOCK);
		REG_RD = 1'b0;
		r = REG_RDATA;
	endtask
	task wait_done(input logic b);
		int i;
		for (i = 0; i < 200; i++) begin
			@(negedge CLOCK);
			if (CONV_DONE === 1'b1 && CONV_IS_BUS === b)
				break;
		end
		if (i == 200) begin
			bad_count++;
			$display("mismatch at %0t: converter stalled", $time);
			wrap_up;
		end
	endtask
	// two bus results, the second ending a full shunt and bus round, then let flags reach the pin
	task settle;
		wait_done(1'b1);
		wait_done(1'b1);
		repeat (6) @(negedge CLOCK);
	endtask
	// config write placed clear of the done-flag set cycle
	task cfg_wr(input logic [15:0] d);
		wait_done(1'b1);
		repeat (2) @(negedge CLOCK);
		wr(8'h00, d);
	endtask
	task t_regs;
		rd(8'h06); chk(r & 16'hFFE7, 16'h0000);
		rd(8'h07); chk(r, 16'h0000);
		wr(8'h07, 16'hFFFF); rd(8'h07); chk(r, 16'hFFFF);
		wr(8'h06, 16'h03E4); rd(8'h06); chk(r & 16'hFFE7, 16'h0000);
		rd(8'h09); chk(r, 16'h0000);
	endtask
	// every function, once violated and once clear
	task t_funcs;
		int   f;
		int   v;
		logic e;
		wr(8'h07, 16'h0100);
		wr(8'h05, 16'h0800);
		for (f = 0; f < 5; f++) begin
			for (v = 0; v < 2; v++) begin
				shunt_val = v ? 16'h0080 : 16'h0200;
				bus_val = v ? 16'h0050 : 16'h8000;
				e = ((f == 1 || f == 3) == (v == 1));
				wr(8'h06, 16'h8000 >> f);
				settle;
				chk({15'h0000, ALERT_OE}, {15'h0000, e});
				rd(8'h06); chk(r & 16'hFC13, (16'h8000 >> f) | (e ? 16'h0010 : 16'h0000));
			end
		end
	endtask
	task t_prio;
		wr(8'h06, 16'hC000); settle; chk({15'h0000, ALERT_OE}, 16'h0000);
		shunt_val = 16'h0200;
		wr(8'h06, 16'h8002); settle; chk({15'h0000, ALERT_OE}, 16'h0000);
	endtask
	task t_latch;
		wr(8'h06, 16'h8001); settle; chk({15'h0000, ALERT_OE}, 16'h0001);
		shunt_val = 16'h0080;
		settle; chk({15'h0000, ALERT_OE}, 16'h0001);
		rd(8'h06); chk(r & 16'h0010, 16'h0010);
		@(negedge CLOCK); chk({15'h0000, ALERT_OE}, 16'h0000);
	endtask
	task t_ready;
		wr(8'h06, 16'h0400); settle; chk({15'h0000, ALERT_OE}, 16'h0001);
		rd(8'h06); chk(r & 16'h0008, 16'h0008);
		rd(8'h06); chk(r & 16'h0008, 16'h0000);
		chk({15'h0000, ALERT_OE}, 16'h0000);
		cfg_wr(16'h0007); rd(8'h06); chk(r & 16'h0008, 16'h0000);
	endtask
	task t_calc;
		wr(8'h06, 16'h0000);
		shunt_val = 16'h0200;
		bus_val = 16'h8000;
		wr(8'h05, 16'h0800); settle;
		rd(8'h04); chk(r, 16'h0200);
		rd(8'h03); chk(r, 16'h0200);
		rd(8'h01); chk(r, 16'h0200);
		rd(8'h02); chk(r, 16'h8000);
		// calibration cleared on the same edge the current is formed, before the bus result
		wait_done(1'b0); wr(8'h05, 16'h0000);
		wait_done(1'b1); repeat (6) @(negedge CLOCK); rd(8'h03); chk(r, 16'h0000);
		shunt_val = 16'h0400;
		wr(8'h05, 16'h0800); settle; cfg_wr(16'h0207);
		shunt_val = 16'h0200;
		wait_done(1'b1); repeat (6) @(negedge CLOCK); rd(8'h04); chk(r, 16'h0400);
		shunt_val = 16'h0600;
		repeat (3) wait_done(1'b1);
		repeat (6) @(negedge CLOCK); rd(8'h04); chk(r, 16'h0500);
		rd(8'h03); chk(r, 16'h0500);
		cfg_wr(16'h0007);
	endtask
	// single shot stops after one cycle; a power-down write keeps the done flag
	task t_single;
		logic [15:0] n;
		n = 16'h0000;
		cfg_wr(16'h0001);
		wait_done(1'b1); repeat (6) @(negedge CLOCK);
		chk({15'h0000, ALERT_OE}, 16'h0001);
		repeat (60) begin
			@(negedge CLOCK);
			if (CONV_START === 1'b1)
				n = n + 16'h0001;
		end
		chk(n, 16'h0000);
		wr(8'h00, 16'h0000); rd(8'h06); chk(r & 16'h0008, 16'h0008);
		rd(8'h06); chk(r & 16'h0008, 16'h0000);
		wr(8'h00, 16'h0007);
	endtask
	initial begin
		repeat (16) @(negedge CLOCK);
		RST = 1'b0;
		t_regs;
		t_funcs;
		t_prio;
		t_latch;
		t_ready;
		t_single;
		t_calc;
		wrap_up;
	end
endmodule // power_monitor_alert_logic_bench

/* power_monitor_alert_logic_sva.sv */
module power_monitor_alert_logic_sva (
	// clock and reset
	input wire logic        CLOCK,
	input wire logic        RST,
	// register port
	input wire logic        REG_WR,
	input wire logic        REG_RD,
	input wire logic [7:0]  REG_ADDR,
	input wire logic [15:0] REG_WDATA,
	input wire logic [15:0] REG_RDATA,
	// converter
	input wire logic        CONV_START,
	input wire logic        CONV_IS_BUS,
	input wire logic        CONV_DONE,
	input wire logic [15:0] CONV_DATA,
	// event pin
	input wire logic        ALERT_OUT,
	input wire logic        ALERT_OE
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [15:0] sel;
	logic [15:0] thr;
	logic [2:0]  mode;
	wire shunt_hi = $signed(CONV_DATA) > $signed(thr);
	wire bus_lo = CONV_DATA < thr;
	wire over_sel = sel[15] && !sel[10] && !sel[0];
	wire under_sel = sel[15:12] == 4'h1 && !sel[10] && !sel[0];
	wire ready_sel = sel[15:10] == 6'h01 && sel[1:0] == 2'h0;
	// shadow of the mode field, event select and threshold registers
	always @(posedge CLOCK) begin
		if (RST) begin
			sel <= 16'h0000;
			thr <= 16'h0000;
			mode <= 3'h7;
		end else if (REG_WR && REG_ADDR == 8'h00) begin
			mode <= REG_WDATA[2:0];
		end else if (REG_WR && REG_ADDR == 8'h06) begin
			sel <= REG_WDATA & 16'hFC03;
		end else if (REG_WR && REG_ADDR == 8'h07) begin
			thr <= REG_WDATA;
		end
	end
	default clocking @(posedge CLOCK); endclocking
	default disable iff (RST);
	a_out_low: assert property (ALERT_OUT == 1'b0) else $error("event data not low");
	a_start_pulse: assert property (CONV_START |=> !CONV_START) else $error("start not a pulse");
	a_bus_follows: assert property (CONV_DONE && !CONV_IS_BUS && !REG_WR |=> CONV_START && CONV_IS_BUS)
		else $error("bus start missing after shunt");
	a_next_shunt: assert property (CONV_DONE && CONV_IS_BUS && !REG_WR && mode == 3'h7 |=> CONV_START && !CONV_IS_BUS)
		else $error("shunt start missing after bus");
	a_unmapped_read: assert property (REG_RD && REG_ADDR > 8'h07 |=> REG_RDATA == 16'h0000)
		else $error("unmapped read not zero");
	a_idle_level: assert property ((sel[15:10] == 6'h00 && $stable(sel)) [*4] |-> ALERT_OE == sel[1])
		else $error("event pin active with nothing selected");
	a_shunt_over: assert property (over_sel && CONV_DONE && !CONV_IS_BUS && !REG_WR ##1 !REG_WR [*2]
		|-> ##1 ALERT_OE == ($past(shunt_hi, 3) != sel[1])) else $error("shunt compare wrong");
	a_bus_under: assert property (under_sel && CONV_DONE && CONV_IS_BUS && !REG_WR ##1 !REG_WR [*2]
		|-> ##1 ALERT_OE == ($past(bus_lo, 3) != sel[1])) else $error("bus compare wrong");
	a_ready_event: assert property (ready_sel && CONV_DONE && CONV_IS_BUS && !REG_WR && !REG_RD
		|-> ##[2:5] ALERT_OE) else $error("ready event missing");
	c_shunt_hit: cover property (over_sel && ALERT_OE);
	c_bus_hit: cover property (under_sel && ALERT_OE);
	c_ready_hit: cover property (ready_sel && ALERT_OE);
endmodule // power_monitor_alert_logic_sva

bind power_monitor_alert_logic power_monitor_alert_logic_sva chk (.CLOCK(CLOCK), .RST(RST), .REG_WR(REG_WR),
	.REG_RD(REG_RD), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA), .CONV_START(CONV_START),
	.CONV_IS_BUS(CONV_IS_BUS), .CONV_DONE(CONV_DONE), .CONV_DATA(CONV_DATA), .ALERT_OUT(ALERT_OUT),
	.ALERT_OE(ALERT_OE));

/* power_monitor_map.vh */
`ifndef POWER_MONITOR_MAP_VH
`define POWER_MONITOR_MAP_VH

// register offsets
`define OFS_CONFIG        8'h00
`define OFS_SHUNT         8'h01
`define OFS_BUS           8'h02
`define OFS_POWER         8'h03
`define OFS_CURRENT       8'h04
`define OFS_CALIBRATION   8'h05
`define OFS_EVENT_SELECT  8'h06
`define OFS_THRESHOLD     8'h07

// reset values
`define RST_CONFIG        16'h0007
`define RST_EVENT_SELECT  16'h0000
`define RST_THRESHOLD     16'h0000
`define RST_CALIBRATION   16'h0000

// configuration fields
`define CFG_MODE_LSB      0
`define CFG_MODE_MSB      2
`define CFG_AVG_LSB       9
`define CFG_AVG_MSB       11
`define MODE_CONTINUOUS   3'h7
`define MODE_OFF_A        3'h0
`define MODE_OFF_B        3'h4

// event select and flag fields
`define EV_SHUNT_OVER     15
`define EV_SHUNT_UNDER    14
`define EV_BUS_OVER       13
`define EV_BUS_UNDER      12
`define EV_POWER_OVER     11
`define EV_READY_ENABLE   10
`define EV_LIMIT_FLAG     4
`define EV_DONE_FLAG      3
`define EV_POLARITY       1
`define EV_LATCH          0

// arithmetic scaling
`define CURRENT_SHIFT     11
`define POWER_SHIFT       15

`endif
